// File: rtl/eeluc_top.sv
`timescale 1ns/1ns
module eeluc_top #(
    parameter int NUM_LINES = eeluc_pkg::NUM_LINES, // Line count.
    parameter int NUM_EXT = eeluc_pkg::NUM_EXT, // Pin-fed line count.
    parameter int NUM_PINS = eeluc_pkg::NUM_PINS // Selectable pin count.
) (
    input wire logic sys_clk, // System clock, 20 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [NUM_PINS-1:0] gpio_pin, // General-purpose pins.
    input wire logic [NUM_LINES-1:0] int_src, // Internal line sources.
    input wire logic [NUM_EXT*eeluc_pkg::SEL_W-1:0] pin_sel, // Pin codes.
    input wire logic [NUM_LINES-1:0] rise_en, // Rising-edge trigger enable.
    input wire logic [NUM_LINES-1:0] fall_en, // Falling-edge trigger enable.
    input wire logic [NUM_LINES-1:0] irq_mask, // 1 lets the interrupt pass.
    input wire logic [NUM_LINES-1:0] evt_mask, // 1 lets the event pass.
    input wire logic [NUM_LINES-1:0] pend_clr, // Write-one-to-clear strobe.
    output logic [NUM_LINES-1:0] pending, // Pending status bits.
    output logic [NUM_LINES-1:0] irq_req, // Interrupt request levels.
    output logic [NUM_LINES-1:0] evt_req, // One-cycle event pulses.
    output logic wake_req // Wake-up request level.
);
    logic [NUM_LINES-1:0] line_src; // Source of each line after selection.
    logic [NUM_LINES-1:0] trig; // Selected edge seen this cycle.
    logic [NUM_LINES-1:0] next_pending; // Next pending value.

    // Pin-fed lines take the pin chosen by their selector code.
    always_comb begin
        line_src = int_src;
        for (int i = 0; i < NUM_EXT; i++) begin
            logic [eeluc_pkg::SEL_W-1:0] code;
            code = pin_sel[i*eeluc_pkg::SEL_W +: eeluc_pkg::SEL_W];
            if (int'(code) < NUM_PINS) begin
                line_src[i] = gpio_pin[code];
            end else begin
                line_src[i] = 1'b0;
            end
        end
    end

    // One edge catcher per line.
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
        eeluc_line_if lif ();
        eeluc_edge_catch u_catch (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .src(line_src[g]),
            .ack_rise(1'b0),
            .ack_fall(1'b0),
            .hit(lif.det)
        );
        // Each line's own trigger selection.
        assign trig[g] = (lif.rise_hit & rise_en[g])
                       | (lif.fall_hit & fall_en[g]);
    end

    // A new edge on an irq_mask-enabled line wins over a clear in the same cycle.
    always_comb begin
        next_pending = (pending & ~pend_clr) | (trig & irq_mask);
    end

    // Pending register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // Event pulses come from the masked edges; wake-up also from any next pending bit.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_req <= '0;
            wake_req <= 1'b0;
        end else begin
            evt_req <= trig & evt_mask;
            wake_req <= |((trig & (irq_mask | evt_mask)) | next_pending);
        end
    end

    // Interrupt request follows the pending bit of an unmasked line.
    assign irq_req = pending & irq_mask;

    // Pending set one cycle after a masked-in edge.
    property p_pend_set;
        @(posedge sys_clk) disable iff (!rst_n)
        (trig[0] && irq_mask[0]) |=> pending[0];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("no pend");
    // Pending holds without a one written.
    property p_pend_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (pending[3] && !pend_clr[3]) |=> pending[3];
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("lost");
    // Clear without new edge drops the bit.
    property p_pend_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        (pend_clr[2] && !trig[2]) |=> !pending[2];
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("no clr");
    // Masked line never raises its interrupt.
    property p_mask;
        @(posedge sys_clk) disable iff (!rst_n)
        !irq_mask[1] |-> !irq_req[1];
    endproperty
    a_mask: assert property (p_mask) else $error("mask leak");
    // Edge without enable does not set pending.
    property p_sel;
        @(posedge sys_clk) disable iff (!rst_n)
        (!pending[4] && !rise_en[4] && !fall_en[4]) |=> !pending[4];
    endproperty
    a_sel: assert property (p_sel) else $error("bad trig");
    // Event follows masked edge.
    property p_evt;
        @(posedge sys_clk) disable iff (!rst_n)
        (trig[5] && evt_mask[5]) |=> evt_req[5];
    endproperty
    a_evt: assert property (p_evt) else $error("no event");
    // Wake-up follows any pending bit.
    property p_wake;
        @(posedge sys_clk) disable iff (!rst_n)
        (|next_pending) |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    // No event pulse without a selected edge just before it.
    property p_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        !trig[6] |=> !evt_req[6];
    endproperty
    a_pulse: assert property (p_pulse) else $error("stray evt");
endmodule

// File: rtl/eeluc_pkg.sv
package eeluc_pkg;
    // Number of edge detector lines.
    localparam int NUM_LINES = 29;
    // Number of lines fed from the pin selector.
    localparam int NUM_EXT = 16;
    // Number of general-purpose pins that may feed the selector.
    localparam int NUM_PINS = 84;
    // Width of one selector code.
    localparam int SEL_W = 7;
    // Reset value of every control bit (all lines disabled).
    localparam logic RST_BIT = 1'b0;
endpackage

// File: rtl/eeluc_line_if.sv
`timescale 1ns/1ns
// Carries one line's synchronised edge strobes.
interface eeluc_line_if;
    logic rise_hit; // One-cycle pulse on a captured rising edge.
    logic fall_hit; // One-cycle pulse on a captured falling edge.
    modport det (output rise_hit, output fall_hit);
    modport core (input rise_hit, input fall_hit);
endinterface

// File: rtl/eeluc_edge_catch.sv
`timescale 1ns/1ns
// Latches an edge of the source asynchronously, then brings it into sys_clk.
module eeluc_edge_catch (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic src, // Raw line source, any width of pulse.
    input wire logic ack_rise, // Unused; nothing clears the rising-edge toggle.
    input wire logic ack_fall, // Unused; nothing clears the falling-edge latch.
    eeluc_line_if.det hit // Synchronised edge strobes.
);
    logic rise_tog; // Toggles on each rising edge of src.
    logic fall_lat; // Toggles on each falling edge of src.
    logic [1:0] rise_sync; // Two-stage synchroniser for rise_tog.
    logic [1:0] fall_sync; // Two-stage synchroniser for fall_lat.
    logic rise_seen; // Stops a held latch from repeating strobes.
    logic fall_seen; // Same for the falling latch.

    // A pulse shorter than a clock period still flips the toggle.
    always_ff @(posedge src or negedge rst_n) begin
        if (!rst_n) begin
            rise_tog <= 1'b0;
        end else begin
            rise_tog <= ~rise_tog;
        end
    end

    // The latch toggles per edge; level is compared below instead.
    always_ff @(negedge src or negedge rst_n) begin
        if (!rst_n) begin
            fall_lat <= 1'b0;
        end else begin
            fall_lat <= ~fall_lat;
        end
    end

    // Two flip-flops carry each latch into the clock domain.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_sync <= 2'h0;
            fall_sync <= 2'h0;
        end else begin
            rise_sync <= {rise_sync[0], rise_tog};
            fall_sync <= {fall_sync[0], fall_lat};
        end
    end

    // A change of a synchronised toggle is one captured edge.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_seen <= 1'b0;
            fall_seen <= 1'b0;
        end else begin
            rise_seen <= rise_sync[1];
            fall_seen <= fall_sync[1];
        end
    end

    assign hit.rise_hit = rise_sync[1] ^ rise_seen;
    assign hit.fall_hit = fall_sync[1] ^ fall_seen;
endmodule

// File: test/eeluc_core_model.sv
`timescale 1ns/1ns
// Far-side receiver: it tallies event pulses and notes pending requests.
module eeluc_core_model #(
    parameter int NUM_CH = 60 // Channels the receiver takes.
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic [NUM_CH-1:0] irq_in, // Interrupt request levels.
    input wire logic [NUM_CH-1:0] evt_in, // One-cycle event pulses.
    output int evt_cnt, // Event pulses seen so far.
    output logic irq_any // Some channel is requesting.
);
    // Every high bit of a pulse counts once, since pulses last one cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_cnt <= 0;
            irq_any <= 1'b0;
        end else begin
            evt_cnt <= evt_cnt + $countones(evt_in);
            irq_any <= |irq_in;
        end
    end
endmodule

// File: test/edge_event_line_controller_tb.sv
`timescale 1ns/1ns
module edge_event_line_controller_tb;
    localparam int N = eeluc_pkg::NUM_LINES;
    logic sys_clk = 1'b0; // System clock.
    logic rst_n = 1'b0; // Reset, active low.
    logic [83:0] gpio = '0; // Pins.
    logic [N-1:0] isrc = '0, ren = '0, fen = '0, clr = '0; // Controls.
    logic [N-1:0] imask = '1, emask = '1; // Masks, all passing.
    logic [111:0] sel = '0; // Pin codes.
    logic [N-1:0] pending, irq_req, evt_req; // Outputs.
    logic wake_req, irq_any; // Wake-up and receiver view.
    int evt_cnt, e0, fails = 0, cmp_count = 0, cyc = 0;
    logic [N-1:0] pend_s, irq_s; // Outputs as settled mid-cycle.
    logic wake_s, irqa_s; // Settled wake-up and receiver view.
    int evt_s; // Settled event tally.
    always #25 sys_clk = ~sys_clk;
    // Takes outputs on the falling edge, well away from the launch edge.
    always @(negedge sys_clk) begin
        pend_s <= pending;
        irq_s <= irq_req;
        wake_s <= wake_req;
        irqa_s <= irq_any;
        evt_s <= evt_cnt;
    end
    eeluc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .gpio_pin(gpio),
        .int_src(isrc), .pin_sel(sel), .rise_en(ren), .fall_en(fen),
        .irq_mask(imask), .evt_mask(emask), .pend_clr(clr),
        .pending(pending), .irq_req(irq_req), .evt_req(evt_req),
        .wake_req(wake_req));
    eeluc_core_model peer (.sys_clk(sys_clk), .rst_n(rst_n),
        .irq_in({31'h0, irq_req}), .evt_in({31'h0, evt_req}),
        .evt_cnt(evt_cnt), .irq_any(irq_any));
    // Compares one value and reports a mismatch.
    task chk(input logic [N-1:0] got, input logic [N-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Pulses the clear strobe for one cycle.
    task clear(input logic [N-1:0] m);
        clr <= m;
        tick(1);
        clr <= '0;
        tick(2);
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            finish_test;
        end
    end
    // Rising edge on an internal line; its fall must be ignored.
    task t_rise;
        e0 = evt_s;
        ren <= 29'h0100000;
        tick(2);
        isrc[20] <= 1'b1;
        tick(6);
        chk(pend_s, 29'h0100000);
        chk(irq_s, 29'h0100000);
        chk(N'(evt_s - e0), 29'h1);
        chk(N'(wake_s), 29'h1);
        chk(N'(irqa_s), 29'h1);
        isrc[20] <= 1'b0;
        tick(6);
        chk(pend_s, 29'h0100000);
        clear(29'h0100000);
        chk(pend_s, 29'h0);
        chk(N'(wake_s), 29'h0);
        chk(N'(irqa_s), 29'h0);
        $display("t_rise done");
    endtask
    // Falling-only line ignores the rise and takes the fall.
    task t_fall;
        ren <= '0;
        fen <= 29'h2000000;
        tick(2);
        isrc[25] <= 1'b1;
        tick(6);
        chk(pend_s, 29'h0);
        isrc[25] <= 1'b0;
        tick(6);
        chk(pend_s, 29'h2000000);
        clear(29'h2000000);
        $display("t_fall done");
    endtask
    // Sub-cycle pulse on the top pin code; a zero write keeps the bit.
    task t_narrow;
        fen <= '0;
        ren <= 29'h8;
        sel[21+:7] <= 7'h53;
        tick(2);
        gpio[83] <= 1'b1;
        #20 gpio[83] <= 1'b0;
        tick(6);
        chk(pend_s, 29'h8);
        clear(29'h4);
        chk(pend_s, 29'h8);
        clear(29'h8);
        chk(pend_s, 29'h0);
        $display("t_narrow done");
    endtask
    // Two lines on both edges, one with its interrupt masked, one with its event masked.
    task t_mask;
        ren <= 29'h60;
        fen <= 29'h60;
        sel[42+:7] <= 7'h01;
        imask <= 29'h1fffffdf;
        emask <= 29'h1fffffbf;
        tick(2);
        e0 = evt_s;
        gpio[1:0] <= 2'b11;
        tick(6);
        chk(pend_s, 29'h40);
        chk(N'(evt_s - e0), 29'h1);
        clear(29'h40);
        gpio[1:0] <= 2'b00;
        tick(6);
        chk(pend_s, 29'h40);
        chk(N'(evt_s - e0), 29'h2);
        clear(29'h40);
        imask <= '1;
        emask <= '1;
        $display("t_mask done");
    endtask
    initial begin
        tick(12);
        rst_n <= 1'b1;
        tick(2);
        t_rise;
        t_fall;
        t_narrow;
        t_mask;
        finish_test;
    end
endmodule
